// ### pdlps_consts.svh
// Constants for the predecoder, length-prefix stall and fusion block
`ifndef PDLPS_CONSTS_SVH
`define PDLPS_CONSTS_SVH
`define PDLPS_MAX_LEN 6'h0f
`define PDLPS_FAST_CYC 4'h1
`define PDLPS_SLOW_CYC 4'h6
`define PDLPS_DOUBLE_CYC 4'hb
`define PDLPS_OSZ 8'h66
`define PDLPS_ASZ 8'h67
`define PDLPS_LOCK 8'hf0
`define PDLPS_REPNE 8'hf2
`define PDLPS_REP 8'hf3
`define PDLPS_ESC 8'h0f
`define PDLPS_GRP_F6 8'hf6
`define PDLPS_GRP_F7 8'hf7
`define PDLPS_FALSE_OFS 4'he
`define PDLPS_DBL_OFS 4'hd
`define PDLPS_LINE_END 5'h0f
`define PDLPS_WIN_LAST 6'h1f
`define PDLPS_PORT_P5 3'h4
`define PDLPS_PORT_ALU 3'h7
`endif

// ### pdlps_pkg.sv
// Types shared by the predecoder files
package pdlps_pkg;
   typedef logic [15:0][7:0] pdlps_line_t;
   typedef logic [31:0][7:0] pdlps_win_t;
   typedef struct packed {
      logic [3:0] len;
      logic [3:0] npfx;
      logic has66;
      logic has67;
      logic length_changing_prefix;
      logic two_byte;
      logic has_modrm;
      logic has_sib;
      logic [1:0] mode_f;
      logic [2:0] opx;
      logic [7:0] op;
      logic cmp;
      logic test;
      logic mem_imm;
      logic cmp_imm8;
      logic jcc;
      logic branch;
      logic bad;
   } pdlps_dec_t;
   typedef struct packed {
      logic [3:0] ofs;
      logic [3:0] len;
      logic [4:0] total;
      logic [7:0] op;
      logic length_changing_prefix;
      logic fused;
      logic branch;
      logic bad;
      logic [2:0] ports;
   } pdlps_uop_t;
endpackage : pdlps_pkg

// ### pdlps_skid2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pdlps_skid2 #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] slot1;
   logic [1:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         count <= 2'h0;
      end else if (push && !pop) begin
         count <= count + 2'h1;
      end else if (pop && !push) begin
         count <= count - 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         out_data <= '0;
         slot1 <= '0;
      end else begin
         if (pop && count == 2'h2) begin
            out_data <= slot1;
         end else if (push && (count == 2'h0 || (pop && count == 2'h1))) begin
            out_data <= in_data;
         end
         if (push && (count == 2'h1 && !pop || count == 2'h2)) begin
            slot1 <= in_data;
         end
      end
   end
endmodule : pdlps_skid2
`default_nettype wire

// ### pdlps_predecode.sv
// Predecoder with length-changing prefix stalls and compare-branch fusion
// Function
// - Instruction lengths from one up to fifteen bytes are accepted.
// - Fast path finds boundaries assuming no length-changing prefix.
// - A line holding a length-changing prefix takes six cycles, not one.
// - Bytes 66h and 67h are the length-changing prefixes.
// - Fixed sixteen-bit immediates without a size prefix cause no stall.
// - Wide register prefixes in 64-bit mode never cause the stall.
// - Prefixed split between form and index byte, or offset 13 byte-displacement, stalls twice.
// - A double stall costs eleven cycles in total.
// - Other prefixed addressing forms stall once wherever they start.
// - Prefixed F7 group at offset 14 stalls like a true prefix stall.
// - The false-stall case waits for the following line before resolving length.
// - Compare register-immediate with unsigned branch fuses; memory-immediate compare does not.
// - Test of operand with itself equals compare with zero in flags.
// - A fused compare-branch issues only to port 5.
// - Unfused simple ALU operations may go to ports 0, 1 or 5.
// - Compare or test fuses with the next conditional branch, dispatching once.
// - Memory-immediate compare or test never fuses.
`timescale 1ns/1ns
`default_nettype none
`include "pdlps_consts.svh"
module pdlps_predecode (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic mode_64,
   input wire logic fetch_valid,
   output logic fetch_ready,
   input wire pdlps_pkg::pdlps_line_t fetch_line,
   output logic uop_valid,
   input wire logic uop_ready,
   output pdlps_pkg::pdlps_uop_t uop,
   output logic stall_active
);
   import pdlps_pkg::*;

   function automatic logic [7:0] byte_at(input pdlps_win_t w, input logic [5:0] idx);
      byte_at = idx[5] ? 8'h00 : w[idx[4:0]];
   endfunction : byte_at

   // Length and class decode at one byte position; slow applies prefix sizes
   function automatic pdlps_dec_t decode_at(input pdlps_win_t w, input logic [4:0] pos,
                                            input logic m64, input logic slow);
      pdlps_dec_t d;
      logic [5:0] i;
      logic [5:0] n;
      logic [7:0] op;
      logic [7:0] rmb;
      logic [7:0] sb;
      logic done;
      logic low;
      logic i8;
      logic zi;
      logic moffs;
      logic a16;
      d = '0;
      i = {1'b0, pos};
      n = 6'h0;
      op = 8'h00;
      rmb = 8'h00;
      sb = 8'h00;
      done = 1'b0;
      low = 1'b0;
      i8 = 1'b0;
      zi = 1'b0;
      moffs = 1'b0;
      a16 = 1'b0;
      for (int k = 0; k < 14; k++) begin
         op = byte_at(w, i);
         if (!done && (op == `PDLPS_OSZ || op == `PDLPS_ASZ || op == `PDLPS_LOCK ||
                       op == `PDLPS_REPNE || op == `PDLPS_REP ||
                       (m64 && op[7:4] == 4'h4))) begin
            d.has66 = d.has66 | (op == `PDLPS_OSZ);
            d.has67 = d.has67 | (op == `PDLPS_ASZ);
            d.npfx = d.npfx + 4'h1;
            i = i + 6'h1;
         end else begin
            done = 1'b1;
         end
      end
      op = byte_at(w, i);
      if (op == `PDLPS_ESC) begin
         d.two_byte = 1'b1;
         i = i + 6'h1;
         op = byte_at(w, i);
      end
      d.op = op;
      i = i + 6'h1;
      rmb = byte_at(w, i);
      d.opx = rmb[5:3];
      d.mode_f = rmb[7:6];
      low = (op[7:6] == 2'h0);
      if (d.two_byte) begin
         d.has_modrm = (op[7:4] != 4'h8);
         zi = (op[7:4] == 4'h8);
         d.jcc = zi;
         d.branch = zi;
      end else begin
         d.has_modrm = (low && !op[2]) || op == 8'h69 || op == 8'h6b || op[7:4] == 4'h8 ||
                       op == 8'hc0 || op == 8'hc1 || op == 8'hc6 || op == 8'hc7 ||
                       op[7:2] == 6'h34 || op == `PDLPS_GRP_F6 || op == `PDLPS_GRP_F7 ||
                       op == 8'hfe || op == 8'hff;
         i8 = (low && op[2:0] == 3'h4) || op == 8'h6a || op == 8'h6b || op[7:4] == 4'h7 ||
              op == 8'h80 || op == 8'h83 || op == 8'ha8 || op[7:3] == 5'h16 ||
              op == 8'hc0 || op == 8'hc1 || op == 8'hc6 || op == 8'heb ||
              (op == `PDLPS_GRP_F6 && !rmb[5] && !rmb[4]);
         zi = (low && op[2:0] == 3'h5) || op == 8'h68 || op == 8'h69 || op == 8'h81 ||
              op == 8'ha9 || op[7:3] == 5'h17 || op == 8'hc7 || op == 8'he8 ||
              op == 8'he9 || (op == `PDLPS_GRP_F7 && !rmb[5] && !rmb[4]);
         moffs = (op[7:2] == 6'h28);
         d.jcc = (op[7:4] == 4'h7);
         d.branch = d.jcc || op == 8'he8 || op == 8'he9 || op == 8'heb ||
                    op == 8'hc2 || op == 8'hc3;
         d.cmp = (op[7:3] == 5'h07 && op[2:0] <= 3'h5) ||
                 ((op == 8'h80 || op == 8'h81 || op == 8'h83) && rmb[5:3] == 3'h7);
         d.test = op == 8'h84 || op == 8'h85 || op == 8'ha8 || op == 8'ha9 ||
                  ((op == `PDLPS_GRP_F6 || op == `PDLPS_GRP_F7) && rmb[5:4] == 2'h0);
         d.mem_imm = (op == 8'h80 || op == 8'h81 || op == 8'h83 || op == `PDLPS_GRP_F6 ||
                      op == `PDLPS_GRP_F7) && rmb[7:6] != 2'h3;
         d.cmp_imm8 = (op == 8'h83 && rmb[5:3] == 3'h7 && rmb[7:6] == 2'h3) || op == 8'h3c;
      end
      if (d.has_modrm) begin
         i = i + 6'h1;
         a16 = slow && d.has67 && !m64;
         if (rmb[7:6] != 2'h3) begin
            if (a16) begin
               if (rmb[7:6] == 2'h1) begin
                  i = i + 6'h1;
               end else if (rmb[7:6] == 2'h2 || rmb[2:0] == 3'h6) begin
                  i = i + 6'h2;
               end
            end else begin
               if (rmb[2:0] == 3'h4) begin
                  d.has_sib = 1'b1;
                  sb = byte_at(w, i);
                  i = i + 6'h1;
               end
               if (rmb[7:6] == 2'h1) begin
                  i = i + 6'h1;
               end else if (rmb[7:6] == 2'h2 || rmb[2:0] == 3'h5 ||
                            (d.has_sib && sb[2:0] == 3'h5)) begin
                  i = i + 6'h4;
               end
            end
         end
      end
      if (i8) begin
         i = i + 6'h1;
      end
      if (zi) begin
         i = i + ((slow && d.has66) ? 6'h2 : 6'h4);
      end
      // Fixed sixteen_bit_immediate forms: size never depends on a prefix
      if (!d.two_byte && (op == 8'hc2 || op == 8'hca)) begin
         i = i + 6'h2;
      end
      if (!d.two_byte && op == 8'hc8) begin
         i = i + 6'h3;
      end
      if (moffs) begin
         i = i + (m64 ? ((slow && d.has67) ? 6'h4 : 6'h8) : ((slow && d.has67) ? 6'h2 : 6'h4));
      end
      d.length_changing_prefix = (d.has66 && zi) || (d.has67 && (d.has_modrm || moffs));
      n = i - {1'b0, pos};
      d.bad = (n > `PDLPS_MAX_LEN);
      d.len = d.bad ? 4'(`PDLPS_MAX_LEN) : n[3:0];
      decode_at = d;
   endfunction : decode_at

   function automatic logic cmp_cc_fusable(input logic [3:0] cc);
      cmp_cc_fusable = !(cc[2:1] == 2'h0 && !cc[3]) && !(cc[3:2] == 2'h2);
   endfunction : cmp_cc_fusable

   pdlps_line_t a_line;
   pdlps_line_t b_line;
   pdlps_win_t win;
   pdlps_dec_t d1f;
   pdlps_dec_t d1s;
   pdlps_dec_t d2;
   pdlps_uop_t next_uop;
   logic a_vld;
   logic b_vld;
   logic a_chg;
   logic b_chg;
   logic [3:0] cursor;
   logic [3:0] stall_cnt;
   logic lcp_eff;
   logic can_dec;
   logic charge;
   logic dbl;
   logic stalled;
   logic issue;
   logic fuse;
   logic cmp_zero;
   logic first_ok;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [3:0] len1;
   logic [4:0] mpos;
   logic [4:0] p2;
   logic [5:0] end2;
   logic [4:0] total;
   logic [4:0] next_cursor;

   assign win = {b_line, a_line};
   assign d1f = decode_at(win, {1'b0, cursor}, mode_64, 1'b0);
   assign d1s = decode_at(win, {1'b0, cursor}, mode_64, 1'b1);
   // False stall: prefixed F7 group at offset 14, whose ModRM byte lies in the next line
   assign lcp_eff = d1s.length_changing_prefix || (d1s.has66 && !d1s.two_byte && d1s.op == `PDLPS_GRP_F7 &&
                                cursor == `PDLPS_FALSE_OFS);
   // Any start past zero may run into the next line, so wait for it
   assign can_dec = a_vld && (cursor == 4'h0 || b_vld);
   assign len1 = lcp_eff ? d1s.len : d1f.len;
   assign mpos = {1'b0, cursor} + {1'b0, d1s.npfx} + {4'h0, d1s.two_byte} + 5'h01;
   assign dbl = (d1s.has_sib && mpos == `PDLPS_LINE_END) ||
                (cursor == `PDLPS_DBL_OFS && d1s.has_modrm && d1s.mode_f == 2'h1);
   assign charge = can_dec && lcp_eff && !a_chg && stall_cnt == 4'h0;
   assign stalled = (stall_cnt != 4'h0) || charge;

   assign p2 = {1'b0, cursor} + {1'b0, len1};
   assign d2 = decode_at(win, p2, mode_64, 1'b0);
   assign end2 = {1'b0, p2} + {2'h0, d2.len};
   // Compare with zero sets flags as a self test, so it fuses as one
   assign cmp_zero = d1s.cmp_imm8 &&
                     byte_at(win, {2'h0, cursor} + {2'h0, len1} - 6'h01) == 8'h00;
   assign first_ok = (d1s.test || (d1s.cmp && (cmp_zero || cmp_cc_fusable(d2.op[3:0])))) &&
                     !d1s.mem_imm && !lcp_eff && !d1s.bad;
   // Branch ending before the last byte of line A fuses before line B arrives, without a shift
   assign fuse = first_ok && d2.jcc && d2.npfx == 4'h0 && !d2.bad &&
                 (b_vld ? end2 <= `PDLPS_WIN_LAST
                        : end2 <= {1'b0, `PDLPS_LINE_END});
   assign total = fuse ? ({1'b0, len1} + {1'b0, d2.len}) : {1'b0, len1};
   assign next_cursor = {1'b0, cursor} + total;
   assign issue = can_dec && !stalled && buf_in_ready && (!lcp_eff || a_chg);
   assign fetch_ready = !stalled && (!a_vld || !b_vld);
   assign stall_active = stalled;

   always_comb begin
      next_uop.ofs = cursor;
      next_uop.len = len1;
      next_uop.total = total;
      next_uop.op = d1s.op;
      next_uop.length_changing_prefix = lcp_eff;
      next_uop.fused = fuse;
      next_uop.branch = d1s.branch;
      next_uop.bad = d1s.bad;
      // Fused pair takes only the branch port; plain ALU work takes any
      next_uop.ports = (fuse || d1s.branch) ? `PDLPS_PORT_P5 : `PDLPS_PORT_ALU;
   end

   // Penalty counter: six cycles for one line, eleven for a split pair
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stall_cnt <= 4'h0;
      end else if (charge) begin
         stall_cnt <= dbl ? (`PDLPS_DOUBLE_CYC - `PDLPS_FAST_CYC - 4'h1)
                          : (`PDLPS_SLOW_CYC - `PDLPS_FAST_CYC - 4'h1);
      end else if (stall_cnt != 4'h0) begin
         stall_cnt <= stall_cnt - 4'h1;
      end
   end

   // Line window, cursor and per-line penalty marks
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         a_line <= '0;
         b_line <= '0;
         a_vld <= 1'b0;
         b_vld <= 1'b0;
         a_chg <= 1'b0;
         b_chg <= 1'b0;
         cursor <= 4'h0;
      end else begin
         if (charge) begin
            a_chg <= 1'b1;
            b_chg <= dbl;
         end
         if (issue && next_cursor[4]) begin
            a_line <= b_line;
            a_chg <= b_chg;
            b_vld <= 1'b0;
            b_chg <= 1'b0;
         end
         if (issue) begin
            cursor <= next_cursor[3:0];
         end
         if (fetch_valid && fetch_ready) begin
            if (!a_vld) begin
               a_line <= fetch_line;
               a_vld <= 1'b1;
               cursor <= 4'h0;
            end else begin
               b_line <= fetch_line;
               b_vld <= 1'b1;
            end
         end
      end
   end

   pdlps_skid2 #(
      .WIDTH($bits(pdlps_uop_t))
   ) u_outbuf (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .in_valid(issue),
      .in_ready(buf_in_ready),
      .in_data(next_uop),
      .out_valid(buf_out_valid),
      .out_ready(uop_ready && !stalled),
      .out_data(uop)
   );
   assign uop_valid = buf_out_valid && !stalled;

   default clocking pdlps_cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   a_len_bound: assert property (uop_valid |-> uop.len != 4'h0)
      else $error("zero instruction length offered");
   a_cursor_step: assert property (issue |=> cursor == $past(next_cursor[3:0]))
      else $error("cursor did not advance by the issued length");
   a_single_pace: assert property ((charge && !dbl) |->
                                   (!issue)[*5] ##1 (stall_cnt == 4'h0 && a_chg))
      else $error("single penalty not six cycles");
   a_lcp_cause: assert property (charge |-> (d1s.has66 || d1s.has67))
      else $error("stall without a length-changing prefix");
   a_plain_free: assert property ((can_dec && !d1s.has66 && !d1s.has67) |-> !lcp_eff)
      else $error("unprefixed instruction marked for slow decode");
   a_double_pace: assert property ((charge && dbl) |->
                                   (!issue)[*8] ##1 !issue ##1 !issue ##1 stall_cnt == 4'h0)
      else $error("double penalty not eleven cycles");
   a_false_stall: assert property ((can_dec && cursor == `PDLPS_FALSE_OFS && d1s.has66 &&
                                    !d1s.two_byte && d1s.op == `PDLPS_GRP_F7 && !a_chg &&
                                    stall_cnt == 4'h0) |-> charge)
      else $error("false stall case not charged");
   a_wait_next: assert property ((a_vld && cursor != 4'h0 && !b_vld) |-> !issue)
      else $error("decoded before the next line arrived");
   a_memimm_nofuse: assert property ((issue && d1s.mem_imm) |-> !fuse)
      else $error("memory-immediate compare was fused");
   a_fused_port: assert property ((uop_valid && uop.fused) |-> uop.ports == `PDLPS_PORT_P5)
      else $error("fused pair not on port 5 alone");
   a_alu_port: assert property ((uop_valid && !uop.fused && !uop.branch) |->
                                uop.ports == `PDLPS_PORT_ALU)
      else $error("plain ALU operation not on ports 0, 1, 5");
   a_stall_hold: assert property (stalled |-> (!uop_valid && !fetch_ready && !issue))
      else $error("flow not held during penalty");

   c_single: cover property (charge && !dbl);
   c_double: cover property (charge && dbl);
   c_fused: cover property (issue && fuse);
   c_false: cover property (charge && d1s.op == `PDLPS_GRP_F7 && cursor == `PDLPS_FALSE_OFS);
endmodule : pdlps_predecode
`default_nettype wire

// ### pdlps_fetch_model.sv
// Fetch source and decoder sink facing the predecoder
`timescale 1ns/1ns
`default_nettype none
module pdlps_fetch_model (
   input wire logic clk_sys,
   input wire logic resetn,
   output logic fetch_valid,
   input wire logic fetch_ready,
   output pdlps_pkg::pdlps_line_t fetch_line,
   input wire logic uop_valid,
   output logic uop_ready,
   input wire pdlps_pkg::pdlps_uop_t uop,
   input wire logic [6:0] ready_pct
);
   import pdlps_pkg::*;
   pdlps_line_t lq[$];
   pdlps_uop_t got[$];
   initial begin
      fetch_valid = 1'b0;
      fetch_line = '0;
      uop_ready = 1'b0;
   end
   // Lines held until taken; idle data toggles so stale bytes never look valid
   always @(posedge clk_sys) begin
      if (!resetn) begin
         fetch_valid <= 1'b0;
         uop_ready <= 1'b0;
         got.delete();
      end else begin
         if (uop_valid && uop_ready) begin
            got.push_back(uop);
         end
         uop_ready <= ($urandom_range(99) < ready_pct);
         if (fetch_valid && fetch_ready) begin
            lq.delete(0);
         end
         if (lq.size() > 0) begin
            fetch_valid <= 1'b1;
            fetch_line <= lq[0];
         end else begin
            fetch_valid <= 1'b0;
            fetch_line <= ~fetch_line;
         end
      end
   end
endmodule : pdlps_fetch_model
`default_nettype wire

// ### test_predecode_length_prefix_stall.sv
// Self-checking bench for the predecoder
`timescale 1ns/1ns
`default_nettype none
module test_predecode_length_prefix_stall;
   import pdlps_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic mode_64 = 1'b0;
   logic fetch_valid, fetch_ready, uop_valid, uop_ready, stall_active;
   pdlps_line_t fetch_line;
   pdlps_uop_t uop;
   logic [6:0] ready_pct = 7'h64;
   int num_errors = 0;
   int check_count = 0;
   int stall_cnt = 0;
   logic [7:0] bytes[$];
   logic [39:0] tpat[6] = '{40'h90, 40'hc089, 40'h05, 40'hc08948, 40'hc2, 40'h05c083};
   int tlen[6] = '{1, 2, 5, 3, 3, 3};

   always #25 clk_sys = ~clk_sys;

   pdlps_predecode DUT (.clk_sys(clk_sys), .resetn(resetn), .mode_64(mode_64),
      .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .fetch_line(fetch_line),
      .uop_valid(uop_valid), .uop_ready(uop_ready), .uop(uop), .stall_active(stall_active));
   pdlps_fetch_model fm (.clk_sys(clk_sys), .resetn(resetn), .fetch_valid(fetch_valid),
      .fetch_ready(fetch_ready), .fetch_line(fetch_line), .uop_valid(uop_valid),
      .uop_ready(uop_ready), .uop(uop), .ready_pct(ready_pct));

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask : check

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Stall cycles since reset, and no word offered while stalled
   always @(posedge clk_sys) begin
      if (!resetn) begin
         stall_cnt <= 0;
      end else if (stall_active === 1'b1) begin
         stall_cnt <= stall_cnt + 1;
      end
      if (resetn && uop_valid === 1'b1) begin
         check(64'(stall_active), 64'h0);
      end
   end

   // Reset for five cycles while the byte stream is queued as whole lines
   task automatic load(input logic m64);
      pdlps_line_t ln;
      resetn <= 1'b0;
      mode_64 <= m64;
      @(posedge clk_sys);
      fm.lq.delete();
      repeat (32) bytes.push_back(8'h90);
      while (bytes.size() % 16 != 0) bytes.push_back(8'h90);
      for (int i = 0; i < bytes.size(); i++) begin
         ln[i % 16] = bytes[i];
         if (i % 16 == 15) fm.lq.push_back(ln);
      end
      bytes.delete();
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
   endtask : load

   task automatic wait_uops(input int n);
      int i;
      for (i = 0; i < 3000 && fm.got.size() < n; i++) @(posedge clk_sys);
      if (fm.got.size() < n) begin
         $display("[ERR] t=%0t timeout got=%h exp=%h", $time, fm.got.size(), n);
         num_errors++;
         report_and_stop();
      end
   endtask : wait_uops

   // Nops up to offset st, np repeat prefixes, then the pattern
   task automatic run_case(input int st, input int np, input logic [63:0] pat, input int n,
         input logic m64, input logic [3:0] el, input logic [4:0] et, input logic [7:0] eo,
         input logic ef, input logic [2:0] ep, input int es);
      pdlps_uop_t u;
      logic [25:0] want;
      repeat (st) bytes.push_back(8'h90);
      repeat (np) bytes.push_back(8'hf3);
      for (int i = 0; i < n; i++) bytes.push_back(pat[8*i +: 8]);
      load(m64);
      wait_uops(st + 2);
      u = fm.got[st];
      want = {4'(st), el, et, eo, es != 0, ef, ep};
      check(64'({u.ofs, u.len, u.total, u.op, u.length_changing_prefix, u.fused, u.ports}), 64'(want));
      check(64'(stall_cnt), 64'(es));
      $display("case at offset %0d done", st);
   endtask : run_case

   // Random mix of forms without 66h or 67h prefixes under random downstream stalls
   task automatic run_random();
      pdlps_uop_t exp[$];
      pdlps_uop_t e;
      logic [39:0] p;
      int k;
      int pos;
      pos = 0;
      for (int j = 0; j < 40; j++) begin
         k = $urandom_range(5);
         p = tpat[k];
         if (k == 2 || k == 4) p[39:8] = $urandom;
         e = '0;
         e.ofs = 4'(pos);
         e.len = 4'(tlen[k]);
         e.total = 5'(tlen[k]);
         e.op = (k == 3) ? p[15:8] : p[7:0];
         e.branch = (k == 4);
         e.ports = (k == 4) ? 3'h4 : 3'h7;
         exp.push_back(e);
         for (int i = 0; i < tlen[k]; i++) bytes.push_back(p[8*i +: 8]);
         pos += tlen[k];
      end
      ready_pct <= 7'h32;
      load(1'b1);
      wait_uops(40);
      for (int j = 0; j < 40; j++) check(64'(fm.got[j]), 64'(exp[j]));
      check(64'(stall_cnt), 64'h0);
      ready_pct <= 7'h64;
      $display("random stream of %0d bytes done", pos);
   endtask : run_random

   initial begin
      void'($urandom(59227));
      run_case(0, 0, 64'h1234c08166, 5, 1'b0, 4'h5, 5'h05, 8'h81, 1'b0, 3'h7, 5);
      run_case(0, 0, 64'h008b67, 3, 1'b0, 4'h3, 5'h03, 8'h8b, 1'b0, 3'h7, 5);
      run_case(13, 0, 64'h123412408166, 6, 1'b0, 4'h6, 5'h06, 8'h81, 1'b0, 3'h7, 10);
      run_case(13, 0, 64'h123430048166, 6, 1'b0, 4'h6, 5'h06, 8'h81, 1'b0, 3'h7, 10);
      run_case(13, 0, 64'h1234008166, 5, 1'b0, 4'h5, 5'h05, 8'h81, 1'b0, 3'h7, 5);
      run_case(14, 0, 64'hd8f766, 3, 1'b0, 4'h3, 5'h03, 8'hf7, 1'b0, 3'h7, 5);
      run_case(0, 0, 64'h010010c8, 4, 1'b0, 4'h4, 5'h04, 8'hc8, 1'b0, 3'h7, 0);
      run_case(0, 0, 64'h05730000004d3d, 7, 1'b1, 4'h5, 5'h07, 8'h3d, 1'b1, 3'h4, 0);
      run_case(0, 0, 64'h057d4d3883, 5, 1'b0, 4'h3, 5'h03, 8'h83, 1'b0, 3'h7, 0);
      run_case(0, 0, 64'h057ec985, 4, 1'b0, 4'h2, 5'h04, 8'h85, 1'b1, 3'h4, 0);
      run_case(0, 0, 64'h057800f983, 5, 1'b0, 4'h3, 5'h05, 8'h83, 1'b1, 3'h4, 0);
      run_case(0, 0, 64'h05740000000100f7, 8, 1'b0, 4'h6, 5'h06, 8'hf7, 1'b0, 3'h7, 0);
      run_case(0, 10, 64'h1234567805, 5, 1'b0, 4'hf, 5'h0f, 8'h05, 1'b0, 3'h7, 0);
      run_case(0, 0, 64'h12345678c08148, 7, 1'b1, 4'h7, 5'h07, 8'h81, 1'b0, 3'h7, 0);
      repeat (2) run_random();
      report_and_stop();
   end
endmodule : test_predecode_length_prefix_stall
`default_nettype wire
